// ---- rtl/pls_level_switch.sv ----
module pls_level_switch
  import pls_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // service channel
  input  wire pls_req_s    svc_req,
  output pls_rsp_s         svc_rsp,
  // communication state machine follow request (when coupled)
  input  wire logic        comm_req_param,
  input  wire logic        comm_req_oper,
  // parameter checker
  output logic             check_start,
  input  wire pls_chk_s    check_res,
  // monitoring
  output logic             monitor_on,
  // level status and acknowledges
  output logic             level_param,
  output pls_ack_e         enter_ack,
  output pls_ack_e         exit_ack
);

  pls_state_e   state;
  logic [15:0]  enter_cmd;
  logic [15:0]  exit_cmd;
  logic [15:0]  coupling;
  logic         check_fault;
  logic [$clog2(PLS_MON_CYC+1)-1:0] mon_cnt;

  // decoded requests
  logic         wr_enter;
  logic         wr_exit;
  logic         wr_cpl;
  logic         decoupled;
  logic         enter_exec;
  logic         exit_exec;
  logic         list_clear;
  logic         list_push;
  logic [31:0]  list_data;
  logic [PLS_LIST_AW:0] list_count;
  // refusal decodes, shared by the store, the acks and the answer; leave decode for the check start
  logic         enter_refuse;
  logic         exit_refuse;
  logic         leave_param;

  function automatic logic cmd_exec(input logic [15:0] w);
    cmd_exec = w[PLS_CMD_SET_BIT] & w[PLS_CMD_EXEC_BIT];
  endfunction : cmd_exec

  // a write that carries the given parameter ident
  function automatic logic svc_write_to(input pls_req_s r, input logic [15:0] id);
    svc_write_to = r.valid && r.write && r.ident == id;
  endfunction : svc_write_to

  // an executing command is refused unless its starting level is active
  function automatic logic cmd_refused(input logic       exec,
                                       input pls_state_e st,
                                       input pls_state_e need);
    cmd_refused = exec && st != need;
  endfunction : cmd_refused

  assign wr_enter     = svc_write_to(svc_req, PLS_ID_ENTER);
  assign wr_exit      = svc_write_to(svc_req, PLS_ID_EXIT);
  assign wr_cpl       = svc_write_to(svc_req, PLS_ID_COUPLING);
  assign decoupled    = coupling[PLS_COUPLE_BIT];
  assign enter_exec   = wr_enter && cmd_exec(svc_req.wdata);
  assign exit_exec    = wr_exit && cmd_exec(svc_req.wdata);
  assign enter_refuse = cmd_refused(enter_exec, state, PLS_ST_OPER);
  assign exit_refuse  = cmd_refused(exit_exec, state, PLS_ST_PARAM);
  assign leave_param  = (exit_exec && decoupled) || (!decoupled && comm_req_oper);
  assign list_clear   = exit_exec && state == PLS_ST_PARAM;
  assign list_push    = state == PLS_ST_CHECK && check_res.valid && check_res.fault;

  // command words; a command refused as not executable is not stored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enter_cmd <= PLS_CMD_RESET;
    end else if (wr_enter && !enter_refuse) begin
      enter_cmd <= svc_req.wdata;
    end
  end

  // same rule for the exit word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exit_cmd <= PLS_CMD_RESET;
    end else if (wr_exit && !exit_refuse) begin
      exit_cmd <= svc_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coupling <= PLS_CPL_RESET;
    end else if (wr_cpl) begin
      coupling <= svc_req.wdata & PLS_CPL_MASK;
    end
  end

  // level state machine
  // coupled it follows the communication requests, decoupled only the commands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PLS_ST_OPER;
    end else begin
      unique case (state)
        PLS_ST_OPER: begin
          if (enter_exec && decoupled) begin
            state <= PLS_ST_PARAM;
          end else if (!decoupled && comm_req_param) begin
            state <= PLS_ST_PARAM;
          end
        end
        PLS_ST_PARAM: begin
          if (exit_exec && decoupled) begin
            state <= PLS_ST_CHECK;
          end else if (!decoupled && comm_req_oper) begin
            state <= PLS_ST_CHECK;
          end
        end
        PLS_ST_CHECK: begin
          if (check_res.valid && check_res.last) begin
            if (check_fault || check_res.fault) begin
              state <= PLS_ST_FAILED;
            end else begin
              state <= PLS_ST_MONON;
            end
          end
        end
        PLS_ST_MONON: begin
          if (mon_cnt == '0) begin
            state <= PLS_ST_OPER;
          end
        end
        PLS_ST_FAILED: begin
          state <= PLS_ST_PARAM;
        end
        default: begin
          state <= PLS_ST_OPER;
        end
      endcase
    end
  end

  // fault accumulator over one check pass
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      check_fault <= 1'b0;
    end else if (state != PLS_ST_CHECK) begin
      check_fault <= 1'b0;
    end else if (check_res.valid && check_res.fault) begin
      check_fault <= 1'b1;
    end
  end

  // settle counter runs only in the switch-on state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_cnt <= '0;
    end else if (state == PLS_ST_CHECK && check_res.valid && check_res.last) begin
      mon_cnt <= ($clog2(PLS_MON_CYC+1))'(PLS_MON_CYC - 1);
    end else if (state == PLS_ST_MONON && mon_cnt != '0) begin
      mon_cnt <= mon_cnt - 1'b1;
    end
  end

  // monitoring is on from reset, comes back on only after the checks pass; off at parameter level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      monitor_on <= 1'b1;
    end else if (state == PLS_ST_MONON) begin
      monitor_on <= 1'b1;
    end else if (state == PLS_ST_PARAM) begin
      monitor_on <= 1'b0;
    end
  end

  // a check pass starts in the same cycle that the level leaves the parameter state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      check_start <= 1'b0;
    end else begin
      check_start <= state == PLS_ST_PARAM && leave_param;
    end
  end

  // status bit 4 of the device status word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_param <= 1'b0;
    end else begin
      level_param <= state != PLS_ST_OPER;
    end
  end

  // acknowledges; positive only once the level bit already shows the new level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enter_ack <= PLS_ACK_NONE;
    end else if (wr_enter && !cmd_exec(svc_req.wdata)) begin
      enter_ack <= PLS_ACK_NONE;
    end else if (enter_refuse) begin
      enter_ack <= PLS_ACK_NEG;
    end else if (enter_exec) begin
      enter_ack <= PLS_ACK_BUSY;
    end else if (enter_ack == PLS_ACK_BUSY && decoupled && state == PLS_ST_PARAM
                 && level_param) begin
      enter_ack <= PLS_ACK_POS;
    end
  end

  // positive exit waits for the level bit to clear so status and ack agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exit_ack <= PLS_ACK_NONE;
    end else if (wr_exit && !cmd_exec(svc_req.wdata)) begin
      exit_ack <= PLS_ACK_NONE;
    end else if (exit_refuse) begin
      exit_ack <= PLS_ACK_NEG;
    end else if (exit_exec) begin
      exit_ack <= PLS_ACK_BUSY;
    end else if (exit_ack == PLS_ACK_BUSY && state == PLS_ST_FAILED) begin
      exit_ack <= PLS_ACK_NEG;
    end else if (exit_ack == PLS_ACK_BUSY && decoupled && state == PLS_ST_OPER
                 && !level_param && !check_fault && monitor_on
                 && list_count == '0) begin
      exit_ack <= PLS_ACK_POS;
    end
  end

  // service channel answer, one cycle after the request
  // reads return data on writes too, so a refused write shows the stored word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      svc_rsp <= '0;
    end else begin
      svc_rsp.valid <= svc_req.valid;
      svc_rsp.error <= 1'b0;
      svc_rsp.code  <= PLS_ERR_NONE;
      svc_rsp.rdata <= 32'h0000_0000;
      if (svc_req.valid) begin
        unique case (svc_req.ident)
          PLS_ID_ENTER: begin
            svc_rsp.rdata <= {16'h0000, enter_cmd};
            if (enter_refuse) begin
              svc_rsp.error <= 1'b1;
              svc_rsp.code  <= PLS_ERR_NOT_EXEC;
            end
          end
          PLS_ID_EXIT: begin
            svc_rsp.rdata <= {16'h0000, exit_cmd};
            if (exit_refuse) begin
              svc_rsp.error <= 1'b1;
              svc_rsp.code  <= PLS_ERR_NOT_EXEC;
            end
          end
          PLS_ID_INVALID: begin
            svc_rsp.rdata <= list_data;
            if (svc_req.write) begin
              svc_rsp.error <= 1'b1;
              svc_rsp.code  <= PLS_ERR_RDONLY;
            end
          end
          PLS_ID_COUPLING: begin
            svc_rsp.rdata <= {16'h0000, coupling & PLS_CPL_MASK};
          end
          default: begin
            svc_rsp.error <= 1'b1;
            svc_rsp.code  <= PLS_ERR_UNMAPPED;
          end
        endcase
      end
    end
  end

  // cleared when an exit command executes at parameter level; a coupled leave on comm_req_oper does not clear it
  pls_invalid_list u_list (
    .clk      (clk),
    .arst_n   (arst_n),
    .clear    (list_clear),
    .push     (list_push),
    .ident    (check_res.ident),
    .rd_index (svc_req.index),
    .rd_data  (list_data),
    .count    (list_count)
  );

endmodule : pls_level_switch

// ---- rtl/pls_pkg.sv ----
package pls_pkg;

  // service channel parameter identifiers of this block
  localparam logic [15:0] PLS_ID_ENTER     = 16'h01a4;
  localparam logic [15:0] PLS_ID_EXIT      = 16'h01a6;
  localparam logic [15:0] PLS_ID_INVALID   = 16'h01a7;
  localparam logic [15:0] PLS_ID_COUPLING  = 16'h01a9;

  // procedure command word: bit 0 set, bit 1 execute
  localparam int          PLS_CMD_SET_BIT  = 0;
  localparam int          PLS_CMD_EXEC_BIT = 1;
  localparam int          PLS_COUPLE_BIT   = 0;
  localparam logic [15:0] PLS_CMD_RESET    = 16'h0000;
  localparam logic [15:0] PLS_CPL_RESET    = 16'h0000;
  localparam logic [15:0] PLS_CPL_MASK     = 16'h0001;

  // acknowledge codes
  localparam logic [15:0] PLS_ERR_NOT_EXEC = 16'h7012;
  localparam logic [15:0] PLS_ERR_NONE     = 16'h0000;
  localparam logic [15:0] PLS_ERR_UNMAPPED = 16'h1001;
  localparam logic [15:0] PLS_ERR_RDONLY   = 16'h7004;
  localparam logic [15:0] PLS_ERR_CHECK    = 16'h7013;

  // invalid list depth and monitoring settle time
  localparam int          PLS_LIST_DEPTH   = 8;
  localparam int          PLS_LIST_AW      = 3;
  localparam int          PLS_MON_ON_NS    = 80;
  localparam int          PLS_CLK_NS       = 8;
  localparam int          PLS_MON_CYC      = (PLS_MON_ON_NS + PLS_CLK_NS - 1) / PLS_CLK_NS;

  typedef enum logic [1:0] {
    PLS_ACK_NONE = 2'b00,
    PLS_ACK_BUSY = 2'b01,
    PLS_ACK_POS  = 2'b10,
    PLS_ACK_NEG  = 2'b11
  } pls_ack_e;

  typedef enum logic [2:0] {
    PLS_ST_OPER   = 3'b000,
    PLS_ST_PARAM  = 3'b001,
    PLS_ST_CHECK  = 3'b010,
    PLS_ST_MONON  = 3'b011,
    PLS_ST_FAILED = 3'b100
  } pls_state_e;

  // service channel request and answer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] ident;
    logic [15:0] wdata;
    logic [PLS_LIST_AW-1:0] index;
  } pls_req_s;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] code;
    logic [31:0] rdata;
  } pls_rsp_s;

  // one parameter check outcome from the application
  typedef struct packed {
    logic        valid;
    logic        last;
    logic        fault;
    logic [31:0] ident;
  } pls_chk_s;

endpackage : pls_pkg

// ---- rtl/pls_invalid_list.sv ----
module pls_invalid_list
  import pls_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // control
  input  wire logic                   clear,
  input  wire logic                   push,
  input  wire logic [31:0]            ident,
  // read port
  input  wire logic [PLS_LIST_AW-1:0] rd_index,
  output logic      [31:0]            rd_data,
  output logic      [PLS_LIST_AW:0]   count
);

  logic [31:0] entry [PLS_LIST_DEPTH];

  // overflow entries are dropped; the count still saturates at the depth
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (push && count < (PLS_LIST_AW+1)'(PLS_LIST_DEPTH)) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !clear && count < (PLS_LIST_AW+1)'(PLS_LIST_DEPTH)) begin
      entry[count[PLS_LIST_AW-1:0]] <= ident;
    end
  end

  // entries past the count read as zero
  always_comb begin
    if ({1'b0, rd_index} < count) begin
      rd_data = entry[rd_index];
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

endmodule : pls_invalid_list

// ---- verification/pls_level_switch_sva.sv ----
module pls_level_switch_sva
  import pls_pkg::*;
(
  // clock and reset
  input wire logic     clk,
  input wire logic     arst_n,
  // watched ports
  input wire pls_req_s svc_req,
  input wire pls_rsp_s svc_rsp,
  input wire logic     check_start,
  input wire pls_chk_s check_res,
  input wire logic     monitor_on,
  input wire logic     level_param,
  input wire pls_ack_e enter_ack,
  input wire pls_ack_e exit_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen_fault;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // an early fault decides the pass even when the last check is clean
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) seen_fault <= 1'b0;
    else if (check_start) seen_fault <= 1'b0;
    else if (check_res.valid && check_res.fault) seen_fault <= 1'b1;
  end
  sequence s_exec(logic [15:0] id);
    svc_req.valid && svc_req.write && svc_req.ident == id && svc_req.wdata[1:0] == 2'h3;
  endsequence
  sequence s_refused;
    svc_rsp.valid && svc_rsp.error && svc_rsp.code == PLS_ERR_NOT_EXEC;
  endsequence
  a_rsp_next_cycle: assert property (svc_req.valid |=> svc_rsp.valid)
    else $error("no answer one cycle after request");
  a_enter_refused: assert property (s_exec(PLS_ID_ENTER) ##0 (level_param &&
    exit_ack != PLS_ACK_BUSY && enter_ack != PLS_ACK_BUSY) |=> s_refused)
    else $error("enter at parameter level not refused");
  a_exit_refused: assert property (s_exec(PLS_ID_EXIT) ##0 (!level_param &&
    enter_ack != PLS_ACK_BUSY) |=> s_refused)
    else $error("exit at operating level not refused");
  a_enter_pos_ack: assert property ($rose(enter_ack == PLS_ACK_POS)
    |-> level_param && !monitor_on) else $error("enter acked before level set");
  a_exit_pos_ack: assert property ($rose(exit_ack == PLS_ACK_POS)
    |-> !level_param && monitor_on) else $error("exit acked before level cleared");
  a_exit_neg_stays: assert property (check_res.valid && check_res.last
    && (check_res.fault || seen_fault)
    |-> ##[1:4] (exit_ack == PLS_ACK_NEG && level_param))
    else $error("failed check not acked negative");
  a_check_starts: assert property (s_exec(PLS_ID_EXIT) ##0 (level_param &&
    exit_ack != PLS_ACK_BUSY) |-> ##1 check_start) else $error("check not started");
  a_monitor_late: assert property (check_res.valid && check_res.last
    && !check_res.fault && !seen_fault
    |-> !monitor_on ##[1:14] monitor_on) else $error("monitoring not switched on");
  a_level_drop: assert property ($fell(level_param)
    |-> ##1 exit_ack == PLS_ACK_POS) else $error("level left without exit ack");
  a_level_rise: assert property ($rose(level_param)
    |-> enter_ack == PLS_ACK_BUSY ##1 enter_ack == PLS_ACK_POS)
    else $error("level entered without enter ack");
endmodule : pls_level_switch_sva

// ---- verification/pls_chk_model.sv ----
module pls_chk_model
  import pls_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // check request and outcome
  input  wire logic       check_start,
  input  wire logic [3:0] fault_mask,
  input  wire logic       slow,
  output pls_chk_s        check_res
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       run;
  logic       tick;
  logic [1:0] idx;
  // slow mode answers every other cycle; idle ident toggles so stale data is never reused
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run       <= 1'h0;
      tick      <= 1'h0;
      idx       <= 2'h0;
      check_res <= '0;
    end else begin
      tick            <= ~tick;
      check_res.valid <= 1'h0;
      check_res.ident <= ~check_res.ident;
      if (check_start) begin
        run <= 1'h1;
        idx <= 2'h0;
      end else if (run && (!slow || tick)) begin
        check_res <= '{1'h1, idx == 2'h3, fault_mask[idx], 32'h100 + 32'(idx)};
        idx       <= idx + 2'h1;
        run       <= idx != 2'h3;
      end
    end
  end
endmodule : pls_chk_model

// ---- verification/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pls_pkg::*;
  logic     clk = 1'h0;
  logic     arst_n = 1'h0;
  pls_req_s req = '0;
  pls_rsp_s rsp;
  pls_rsp_s got;
  logic     comm_req_param = 1'h0;
  logic     comm_req_oper = 1'h0;
  logic     check_start;
  pls_chk_s check_res;
  logic     monitor_on;
  logic     level_param;
  pls_ack_e enter_ack;
  pls_ack_e exit_ack;
  logic [3:0] fault_mask = 4'h0;
  logic     slow = 1'h0;
  int       fail_count = 0;
  int       tests_run = 0;
  int       cycles = 0;
  pls_level_switch i_pls_level_switch (.clk(clk), .arst_n(arst_n), .svc_req(req),
    .svc_rsp(rsp), .comm_req_param(comm_req_param), .comm_req_oper(comm_req_oper),
    .check_start(check_start), .check_res(check_res), .monitor_on(monitor_on),
    .level_param(level_param), .enter_ack(enter_ack), .exit_ack(exit_ack));
  pls_chk_model i_pls_chk_model (.clk(clk), .arst_n(arst_n), .check_start(check_start),
    .fault_mask(fault_mask), .slow(slow), .check_res(check_res));
  always #4 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // long check passes must not hang the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic service_channel(input logic w, input logic [15:0] id, input logic [15:0] wd,
                     input logic [2:0] ix);
    @(posedge clk) #1;
    req <= '{1'h1, w, id, wd, ix};
    @(posedge clk) #1;
    req.valid <= 1'h0;
    req.ident <= ~id;
    got = rsp;
  endtask : service_channel
  task automatic wait_exit(input pls_ack_e e);
    int n;
    n = 0;
    while (exit_ack !== e && n < 60) begin
      @(posedge clk) #1;
      n++;
    end
    chk(32'(exit_ack), 32'(e));
  endtask : wait_exit
  task automatic t_reset();
    chk(32'(level_param), 32'h0);
    chk(32'(monitor_on), 32'h1);
    service_channel(1'h0, PLS_ID_COUPLING, 16'h0, 3'h0);
    chk(got.rdata, 32'(PLS_CPL_RESET));
    service_channel(1'h1, PLS_ID_EXIT, 16'h3, 3'h0);
    chk(32'(got.code), 32'(PLS_ERR_NOT_EXEC));
    chk(32'(got.error), 32'h1);
    chk(32'(exit_ack), 32'(PLS_ACK_NEG));
    service_channel(1'h1, PLS_ID_INVALID, 16'h0, 3'h0);
    chk(32'(got.code), 32'(PLS_ERR_RDONLY));
    service_channel(1'h0, 16'h0001, 16'h0, 3'h0);
    chk(32'(got.code), 32'(PLS_ERR_UNMAPPED));
    chk(32'(got.error), 32'h1);
  endtask : t_reset
  task automatic t_couple();
    service_channel(1'h1, PLS_ID_COUPLING, 16'hfffe, 3'h0);
    service_channel(1'h0, PLS_ID_COUPLING, 16'h0, 3'h0);
    chk(got.rdata, 32'h0);
    service_channel(1'h1, PLS_ID_ENTER, 16'h3, 3'h0);
    chk(32'(enter_ack), 32'(PLS_ACK_BUSY));
    repeat (4) @(posedge clk);
    #1;
    chk(32'(level_param), 32'h0);
    service_channel(1'h1, PLS_ID_ENTER, 16'h0, 3'h0);
    chk(32'(enter_ack), 32'(PLS_ACK_NONE));
    service_channel(1'h1, PLS_ID_COUPLING, 16'hffff, 3'h0);
    service_channel(1'h0, PLS_ID_COUPLING, 16'h0, 3'h0);
    chk(got.rdata, 32'h1);
    comm_req_param = 1'h1;
    repeat (6) @(posedge clk);
    #1;
    chk(32'(level_param), 32'h0);
    comm_req_param = 1'h0;
  endtask : t_couple
  task automatic t_enter();
    service_channel(1'h1, PLS_ID_ENTER, 16'h3, 3'h0);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(level_param), 32'h1);
    chk(32'(enter_ack), 32'(PLS_ACK_POS));
    service_channel(1'h1, PLS_ID_ENTER, 16'h7, 3'h0);
    chk(32'(got.code), 32'(PLS_ERR_NOT_EXEC));
    chk(32'(enter_ack), 32'(PLS_ACK_NEG));
    service_channel(1'h0, PLS_ID_ENTER, 16'h0, 3'h0);
    chk(got.rdata, 32'h3);
  endtask : t_enter
  task automatic t_exit(input logic [3:0] m, input logic s, input pls_ack_e e);
    fault_mask = m;
    slow = s;
    service_channel(1'h1, PLS_ID_EXIT, 16'h3, 3'h0);
    wait_exit(e);
    chk(32'(level_param), 32'(m != 4'h0));
    chk(32'(monitor_on), 32'(m == 4'h0));
    service_channel(1'h0, PLS_ID_INVALID, 16'h0, 3'h0);
    chk(got.rdata, (m == 4'h0) ? 32'h0 : 32'h101);
    service_channel(1'h0, PLS_ID_INVALID, 16'h0, 3'h1);
    chk(got.rdata, (m == 4'h0) ? 32'h0 : 32'h103);
    service_channel(1'h0, PLS_ID_INVALID, 16'h0, 3'h2);
    chk(got.rdata, 32'h0);
  endtask : t_exit
  initial begin
    repeat (4) @(posedge clk);
    #1;
    arst_n = 1'h1;
    t_reset();
    t_couple();
    t_enter();
    t_exit(4'ha, 1'h1, PLS_ACK_NEG);
    // references after the return are re-established by the controller, not here
    t_exit(4'h0, 1'h0, PLS_ACK_POS);
    finish_test();
  end
endmodule : testbench
bind pls_level_switch pls_level_switch_sva i_pls_level_switch_sva (.clk(clk),
  .arst_n(arst_n), .svc_req(svc_req), .svc_rsp(svc_rsp), .check_start(check_start),
  .check_res(check_res), .monitor_on(monitor_on), .level_param(level_param),
  .enter_ack(enter_ack), .exit_ack(exit_ack));
